// ---- design/ssl_cfg.svh ----
// Constants for the soft strap latch and override block
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH
`define SSL_ADDR_W 8
`define SSL_DATA_W 32
`define SSL_STRAP_W 15
`define SSL_IDX_W 4
// Register offsets
`define SSL_OFF_RESET_CONTROL_REG 8'h00
`define SSL_OFF_MEM_CMD 8'h04
`define SSL_OFF_IND_CFG 8'h08
`define SSL_OFF_BASIC_CTL 8'h0C
`define SSL_OFF_ADVERT 8'h10
`define SSL_OFF_MODES 8'h14
`define SSL_OFF_SPECIAL 8'h18
`define SSL_OFF_STRAPS 8'h1C
// Positions in the soft strap vector
`define SSL_SV_SEL_LO 0
`define SSL_SV_FUN_LO 8
`define SSL_SV_AUTOX 10
`define SSL_SV_MANX 11
`define SSL_SV_AN 12
`define SSL_SV_SPD 13
`define SSL_SV_DPX 14
// Tie-off defaults of pinless straps
`define SSL_TIE_MANX 1'h0
`define SSL_TIE_SPD 1'h1
`define SSL_TIE_DPX 1'h1
// Register field positions
`define SSL_RC_DIGITAL 0
`define SSL_RC_BUSY 31
`define SSL_MC_RELOAD 0
`define SSL_MC_BUSY 31
`define SSL_IC_FUN_LO 8
`define SSL_BC_DPX 8
`define SSL_BC_AN 12
`define SSL_BC_SPD 13
`define SSL_ADV_10H 5
`define SSL_ADV_10F 6
`define SSL_SC_CROSS 13
`define SSL_SC_AUTO 14
`define SSL_SC_OVR 15
`define SSL_ST_EFF_LO 0
`define SSL_ST_LAT_LO 16
// Reset values and mode codes
`define SSL_MODE_AUTO 3'h7
`define SSL_SC_RESET 3'h0
`endif

// ---- design/ssl_phy_defaults.sv ----
// Port 1 register defaults derived from the effective straps
`include "ssl_cfg.svh"
module ssl_phy_defaults
  import ssl_pkg::*;
(
  input  ssl_strap_t  strapVec,
  output logic        anDefault,
  output logic        speedDefault,
  output logic        duplexDefault,
  output logic        adv10FullDefault,
  output logic        adv10HalfDefault,
  output logic [2:0]  modeDefault
);
  logic an;
  logic spd;
  logic dpx;

  assign an  = strapVec[`SSL_SV_AN];
  assign spd = strapVec[`SSL_SV_SPD];
  assign dpx = strapVec[`SSL_SV_DPX];

  assign anDefault = an;
  // With negotiation on, the forced speed and duplex bits are moot
  assign speedDefault     = an | spd;
  assign duplexDefault    = an | dpx;
  assign adv10FullDefault = an & dpx;
  assign adv10HalfDefault = an;
  assign modeDefault      = an ? `SSL_MODE_AUTO : {1'b0, spd, dpx};
endmodule

// ---- design/ssl_pkg.sv ----
// Types shared by the soft strap block
package ssl_pkg;
  `include "ssl_cfg.svh"
  typedef enum logic [1:0]
  {
    SSL_ST_RESET = 2'b00,
    SSL_ST_LOAD  = 2'b01,
    SSL_ST_APPLY = 2'b10,
    SSL_ST_READY = 2'b11
  } ssl_state_t;
  typedef logic [`SSL_STRAP_W-1:0] ssl_strap_t;
endpackage

// ---- design/ssl_strap_hold.sv ----
// Per-bit latched and effective soft strap storage
`include "ssl_cfg.svh"
module ssl_strap_hold
  import ssl_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  clkEn,
  input  wire logic                  chipReset,
  input  wire ssl_strap_t            pinVec,
  input  wire logic                  revert,
  input  wire logic                  ldrWrite,
  input  wire logic [`SSL_IDX_W-1:0] ldrIndex,
  input  wire logic                  ldrBit,
  output ssl_strap_t                 latchedVec,
  output ssl_strap_t                 effectiveVec
);
  ssl_strap_t latched_ff;
  ssl_strap_t effective_ff;

  genvar i;
  generate
    for (i = 0; i < `SSL_STRAP_W; i++)
    begin : g_bit
      // Pins tracked during reset, so the last reset cycle is what stays
      always_ff @(posedge sys_clk)
      begin
        if (clkEn && chipReset)
        begin
          latched_ff[i] <= pinVec[i];
        end
      end
      always_ff @(posedge sys_clk)
      begin
        if (clkEn)
        begin
          if (chipReset)
          begin
            effective_ff[i] <= pinVec[i];
          end
          else if (revert)
          begin
            effective_ff[i] <= latched_ff[i];
          end
          else if (ldrWrite && ldrIndex == `SSL_IDX_W'(i))
          begin
            effective_ff[i] <= ldrBit;
          end
        end
      end
    end
  endgenerate

  assign latchedVec   = latched_ff;
  assign effectiveVec = effective_ff;

  AST_LOADER_OVERRIDE: assert property (@(posedge sys_clk)
    clkEn && !chipReset && !revert && ldrWrite && ldrIndex < `SSL_IDX_W'(`SSL_STRAP_W)
    |=> effectiveVec[$past(ldrIndex)] == $past(ldrBit))
    else $error("Loader write did not override strap bit");
  AST_NO_RESAMPLE: assert property (@(posedge sys_clk)
    !chipReset |=> $stable(latchedVec))
    else $error("Latched straps changed outside chip reset");
endmodule

// ---- design/ssl_top.sv ----
// Soft configuration strap latch, override and register defaults
// What this block does
// - Capture all soft strap values when power-on or external reset is released.
// - With memory present, loader values replace the latched strap values.
// - Pinless straps latch their fixed tie-off default instead of a pin.
// - Digital reset or reload with no memory content restores latched values.
// - Digital reset and reload never resample pins; last latched value reused.
// - Indicator select strap sets all eight select defaults; high indicator, low GPIO.
// - One pin feeds all eight select bits; loader writes each bit alone.
// - Two-bit function strap sets matching function bits; high sets, low clears.
// - Override clear: automatic crossover strap enables or disables auto crossover.
// - Override set: the automatic crossover strap has no effect.
// - Auto strap low, override clear: manual strap picks straight or crossed.
// - Negotiation strap sets the port 1 negotiation enable default.
// - Negotiation strap also shapes speed, duplex, advert and mode defaults.
// - The memory loader restarts automatically after a digital reset.
`include "ssl_cfg.svh"
module ssl_top
  import ssl_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  input  wire logic                   externalResetPinN,
  input  wire logic                   indicatorSelectPin,
  input  wire logic [1:0]             indicatorFunctionPin,
  input  wire logic                   autoCrossoverPin,
  input  wire logic                   negotiationPin,
  input  wire logic [`SSL_ADDR_W-1:0] regAddr,
  input  wire logic [`SSL_DATA_W-1:0] regWrData,
  input  wire logic                   regWrStb,
  input  wire logic                   regRdStb,
  output logic [`SSL_DATA_W-1:0]      regRdData,
  input  wire logic                   loaderWrite,
  input  wire logic [`SSL_IDX_W-1:0]  loaderIndex,
  input  wire logic                   loaderBit,
  input  wire logic                   loaderDone,
  output logic                        loaderStart,
  output logic                        deviceReady,
  output logic [7:0]                  indicatorOutputSelect,
  output logic [1:0]                  indicatorFunctionField,
  output logic                        autoCrossoverEn,
  output logic                        crossedWiring,
  output logic                        negotiationEnable,
  output logic                        speedSelectLow,
  output logic                        duplexSelect,
  output logic                        advert10Full,
  output logic                        advert10Half,
  output logic [2:0]                  specialMode
);
  ssl_state_t               state_ff;
  logic [`SSL_DATA_W-1:0]   rdData_ff;
  logic                     loaderStart_ff;
  logic                     ready_ff;
  logic                     phyLoad_ff;
  logic [7:0]               indSel_ff;
  logic [1:0]               indFun_ff;
  logic                     an_ff;
  logic                     speed_ff;
  logic                     duplex_ff;
  logic                     adv10F_ff;
  logic                     adv10H_ff;
  logic [2:0]               mode_ff;
  logic                     xOvr_ff;
  logic                     xSwAuto_ff;
  logic                     xSwCross_ff;
  logic                     autoX_ff;
  logic                     crossed_ff;
  logic [`SSL_DATA_W-1:0]   rdMux;
  logic                     chipReset;
  logic                     inReady;
  logic                     digitalReset;
  logic                     reloadCmd;
  logic                     revert;
  logic                     regWrite;
  ssl_strap_t               pinVec;
  ssl_strap_t               latchedVec;
  ssl_strap_t               effectiveVec;
  logic                     anDef;
  logic                     speedDef;
  logic                     duplexDef;
  logic                     adv10FDef;
  logic                     adv10HDef;
  logic [2:0]               modeDef;

  // External pin acts like power-on reset; both re-latch the pins
  assign chipReset = !rst_n || !externalResetPinN;
  assign inReady   = (state_ff == SSL_ST_READY);
  // Writes before ready are dropped, as software may not touch registers then
  assign regWrite  = regWrStb && inReady;
  assign digitalReset = regWrite && regAddr == `SSL_OFF_RESET_CONTROL_REG && regWrData[`SSL_RC_DIGITAL];
  assign reloadCmd = regWrite && regAddr == `SSL_OFF_MEM_CMD && regWrData[`SSL_MC_RELOAD];
  assign revert    = digitalReset || reloadCmd;

  assign pinVec = {`SSL_TIE_DPX, `SSL_TIE_SPD, negotiationPin, `SSL_TIE_MANX,
                   autoCrossoverPin, indicatorFunctionPin,
                   {8{indicatorSelectPin}}};

  ssl_strap_hold u_hold
  (
    .sys_clk      (sys_clk),
    .clkEn        (clkEn),
    .chipReset    (chipReset),
    .pinVec       (pinVec),
    .revert       (revert),
    .ldrWrite     (loaderWrite && state_ff == SSL_ST_LOAD),
    .ldrIndex     (loaderIndex),
    .ldrBit       (loaderBit),
    .latchedVec   (latchedVec),
    .effectiveVec (effectiveVec)
  );

  ssl_phy_defaults u_phy
  (
    .strapVec         (effectiveVec),
    .anDefault        (anDef),
    .speedDefault     (speedDef),
    .duplexDefault    (duplexDef),
    .adv10FullDefault (adv10FDef),
    .adv10HalfDefault (adv10HDef),
    .modeDefault      (modeDef)
  );

  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (chipReset)
      begin
        state_ff <= SSL_ST_RESET;
      end
      else
      begin
        case (state_ff)
          SSL_ST_RESET: state_ff <= SSL_ST_LOAD;
          SSL_ST_LOAD:  state_ff <= loaderDone ? SSL_ST_APPLY : SSL_ST_LOAD;
          SSL_ST_APPLY: state_ff <= SSL_ST_READY;
          SSL_ST_READY: state_ff <= revert ? SSL_ST_LOAD : SSL_ST_READY;
          default:      state_ff <= SSL_ST_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      loaderStart_ff <= !chipReset && (state_ff == SSL_ST_RESET || (inReady && revert));
      ready_ff       <= !chipReset && (state_ff == SSL_ST_APPLY || (inReady && !revert));
    end
  end

  // Digital reset spares the PHY registers; only chip reset reloads them
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      phyLoad_ff <= chipReset || (phyLoad_ff && state_ff != SSL_ST_APPLY);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (!inReady || chipReset)
      begin
        indSel_ff <= effectiveVec[`SSL_SV_SEL_LO +: 8];
        indFun_ff <= effectiveVec[`SSL_SV_FUN_LO +: 2];
      end
      else if (regWrite && regAddr == `SSL_OFF_IND_CFG)
      begin
        indSel_ff <= regWrData[7:0];
        indFun_ff <= regWrData[`SSL_IC_FUN_LO +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (chipReset || (phyLoad_ff && !inReady))
      begin
        an_ff     <= anDef;
        speed_ff  <= speedDef;
        duplex_ff <= duplexDef;
        adv10F_ff <= adv10FDef;
        adv10H_ff <= adv10HDef;
        mode_ff   <= modeDef;
      end
      else if (regWrite)
      begin
        if (regAddr == `SSL_OFF_BASIC_CTL)
        begin
          an_ff     <= regWrData[`SSL_BC_AN];
          speed_ff  <= regWrData[`SSL_BC_SPD];
          duplex_ff <= regWrData[`SSL_BC_DPX];
        end
        if (regAddr == `SSL_OFF_ADVERT)
        begin
          adv10F_ff <= regWrData[`SSL_ADV_10F];
          adv10H_ff <= regWrData[`SSL_ADV_10H];
        end
        if (regAddr == `SSL_OFF_MODES)
        begin
          mode_ff <= regWrData[2:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (chipReset)
      begin
        {xOvr_ff, xSwAuto_ff, xSwCross_ff} <= `SSL_SC_RESET;
      end
      else if (regWrite && regAddr == `SSL_OFF_SPECIAL)
      begin
        xOvr_ff     <= regWrData[`SSL_SC_OVR];
        xSwAuto_ff  <= regWrData[`SSL_SC_AUTO];
        xSwCross_ff <= regWrData[`SSL_SC_CROSS];
      end
    end
  end

  // Crossover resolved from straps only while the override bit is clear
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (xOvr_ff)
      begin
        autoX_ff   <= xSwAuto_ff;
        crossed_ff <= xSwCross_ff;
      end
      else
      begin
        autoX_ff   <= effectiveVec[`SSL_SV_AUTOX];
        crossed_ff <= !effectiveVec[`SSL_SV_AUTOX] && effectiveVec[`SSL_SV_MANX];
      end
    end
  end

  always_comb
  begin
    rdMux = '0;
    case (regAddr)
      `SSL_OFF_RESET_CONTROL_REG: rdMux[`SSL_RC_BUSY] = !inReady;
      `SSL_OFF_MEM_CMD:   rdMux[`SSL_MC_BUSY] = !inReady;
      `SSL_OFF_IND_CFG:   rdMux[9:0] = {indFun_ff, indSel_ff};
      `SSL_OFF_BASIC_CTL:
      begin
        rdMux[`SSL_BC_AN]  = an_ff;
        rdMux[`SSL_BC_SPD] = speed_ff;
        rdMux[`SSL_BC_DPX] = duplex_ff;
      end
      `SSL_OFF_ADVERT:
      begin
        rdMux[`SSL_ADV_10F] = adv10F_ff;
        rdMux[`SSL_ADV_10H] = adv10H_ff;
      end
      `SSL_OFF_MODES:     rdMux[2:0] = mode_ff;
      `SSL_OFF_SPECIAL:
      begin
        rdMux[`SSL_SC_OVR]   = xOvr_ff;
        rdMux[`SSL_SC_AUTO]  = xSwAuto_ff;
        rdMux[`SSL_SC_CROSS] = xSwCross_ff;
      end
      `SSL_OFF_STRAPS:
      begin
        rdMux[`SSL_ST_EFF_LO +: `SSL_STRAP_W] = effectiveVec;
        rdMux[`SSL_ST_LAT_LO +: `SSL_STRAP_W] = latchedVec;
      end
      default:            rdMux = '0;
    endcase
  end

  // Data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      rdData_ff <= (regRdStb && !chipReset) ? rdMux : '0;
    end
  end

  assign {regRdData, loaderStart, deviceReady, indicatorOutputSelect, indicatorFunctionField}
         = {rdData_ff, loaderStart_ff, ready_ff, indSel_ff, indFun_ff};
  assign {autoCrossoverEn, crossedWiring, negotiationEnable, speedSelectLow, duplexSelect}
         = {autoX_ff, crossed_ff, an_ff, speed_ff, duplex_ff};
  assign {advert10Full, advert10Half, specialMode} = {adv10F_ff, adv10H_ff, mode_ff};
  AST_CAPTURE: assert property (@(posedge sys_clk)
    clkEn && chipReset |=> latchedVec == $past(pinVec))
    else $error("Strap pins not captured during chip reset");
  AST_REVERT: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && revert |=> effectiveVec == latchedVec)
    else $error("Straps did not revert to latched values");
  AST_RESTART: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && digitalReset |=> loaderStart && state_ff == SSL_ST_LOAD)
    else $error("Loader not restarted after digital reset");
  AST_IND_DEFAULT: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && state_ff == SSL_ST_APPLY |=> indicatorOutputSelect == effectiveVec[7:0]
        && indicatorFunctionField == effectiveVec[9:8])
    else $error("Indicator defaults not taken from straps");
  AST_READY_AFTER_APPLY: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && state_ff == SSL_ST_APPLY
    |=> deviceReady && (!$past(phyLoad_ff) || negotiationEnable == $past(anDef)))
    else $error("Defaults not loaded before ready");
  AST_XOVER_OVR: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && xOvr_ff |=> autoCrossoverEn == $past(xSwAuto_ff)
                      && crossedWiring == $past(xSwCross_ff))
    else $error("Crossover strap leaked through override");
  AST_XOVER_STRAP: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && !xOvr_ff |=> autoCrossoverEn == $past(effectiveVec[`SSL_SV_AUTOX])
      && crossedWiring == $past(!effectiveVec[`SSL_SV_AUTOX] && effectiveVec[`SSL_SV_MANX]))
    else $error("Crossover not decided by straps");
  AST_MODE: assert property (@(posedge sys_clk)
    clkEn && rst_n && !externalResetPinN ##1 clkEn && !chipReset
    |-> specialMode == (effectiveVec[`SSL_SV_AN] ? `SSL_MODE_AUTO
        : {1'b0, effectiveVec[`SSL_SV_SPD], effectiveVec[`SSL_SV_DPX]}))
    else $error("Special mode default wrong after reset");
  AST_READ_ONE: assert property (@(posedge sys_clk) disable iff (chipReset)
    clkEn && !regRdStb |=> regRdData == '0)
    else $error("Read data outside the answer cycle");
  COV_REVERT: cover property (@(posedge sys_clk) clkEn && reloadCmd);
  COV_OVERRIDE: cover property (@(posedge sys_clk)
    loaderWrite && state_ff == SSL_ST_LOAD ##[1:20] deviceReady);
  COV_DIGITAL: cover property (@(posedge sys_clk) digitalReset ##[1:20] deviceReady);
endmodule

// ---- tb/ssl_loader_model.sv ----
// Behavioural configuration memory loader for the strap bench
module ssl_loader_model
(
  input  wire logic        sys_clk,
  input  wire logic        loaderStart,
  input  wire logic        present,
  input  wire logic [14:0] ovrMask,
  input  wire logic [14:0] ovrVal,
  input  wire logic [3:0]  delayCyc,
  output logic             loaderWrite,
  output logic [3:0]       loaderIndex,
  output logic             loaderBit,
  output logic             loaderDone,
  output logic [7:0]       startCount
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    loaderWrite = 1'b0;
    loaderIndex = 4'h0;
    loaderBit = 1'b0;
    loaderDone = 1'b0;
    startCount = 8'h00;
    forever
    begin
      @(posedge sys_clk);
      if (loaderStart === 1'b1)
      begin
        startCount <= startCount + 8'h01;
        repeat (delayCyc) @(posedge sys_clk);
        for (int i = 0; i < 15; i++)
        begin
          if (present && ovrMask[i])
          begin
            loaderWrite <= 1'b1;
            loaderIndex <= 4'(i);
            loaderBit   <= ovrVal[i];
            @(posedge sys_clk);
          end
        end
        loaderWrite <= 1'b0;
        // Absent memory still finishes, or the device would hang
        loaderDone  <= 1'b1;
        @(posedge sys_clk);
        loaderDone  <= 1'b0;
      end
      else
      begin
        // Idle lines keep moving so a stale index is never mistaken
        loaderIndex <= loaderIndex + 4'h5;
        loaderBit   <= ~loaderBit;
      end
    end
  end
endmodule

// ---- tb/ssl_top_test.sv ----
// Self-checking bench for the soft strap latch and override block
`include "ssl_cfg.svh"
module ssl_top_test
  import ssl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, clkEn, externalResetPinN;
  logic        indicatorSelectPin, autoCrossoverPin, negotiationPin;
  logic [1:0]  indicatorFunctionPin, indicatorFunctionField;
  logic [7:0]  regAddr, indicatorOutputSelect, startCount;
  logic [31:0] regWrData, regRdData, rd, pv;
  logic        regWrStb, regRdStb, loaderWrite, loaderBit, loaderDone;
  logic        loaderStart, deviceReady, autoCrossoverEn, crossedWiring;
  logic        negotiationEnable, speedSelectLow, duplexSelect;
  logic        advert10Full, advert10Half, present;
  logic [2:0]  specialMode;
  logic [3:0]  loaderIndex, delayCyc;
  ssl_strap_t  ovrMask, ovrVal, lat, m, v, phyS;
  integer      seed, n_mismatch, n_compared;

  ssl_top dut (
    .sys_clk, .rst_n, .clkEn, .externalResetPinN, .indicatorSelectPin,
    .indicatorFunctionPin, .autoCrossoverPin, .negotiationPin, .regAddr,
    .regWrData, .regWrStb, .regRdStb, .regRdData, .loaderWrite, .loaderIndex,
    .loaderBit, .loaderDone, .loaderStart, .deviceReady, .indicatorOutputSelect,
    .indicatorFunctionField, .autoCrossoverEn, .crossedWiring, .negotiationEnable,
    .speedSelectLow, .duplexSelect, .advert10Full, .advert10Half, .specialMode
  );
  ssl_loader_model ldr (
    .sys_clk, .loaderStart, .present, .ovrMask, .ovrVal, .delayCyc,
    .loaderWrite, .loaderIndex, .loaderBit, .loaderDone, .startCount
  );

  always #10 sys_clk = ~sys_clk;

  function automatic ssl_strap_t merge(input ssl_strap_t l, input ssl_strap_t mk,
                                       input ssl_strap_t vl);
    return (l & ~mk) | (vl & mk);
  endfunction

  // Port 1 defaults follow the effective straps of the last chip reset only
  function automatic logic [7:0] phyExp(input ssl_strap_t s);
    logic n;
    n = s[12];
    return {n, n | s[13], n | s[14], n & s[14], n, n ? 3'h7 : {1'b0, s[13], s[14]}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    rd = regRdData;
    @(posedge sys_clk);
    #1;
    check(regRdData, 32'h0, "read data held");
  endtask

  task automatic waitReady();
    int i;
    i = 0;
    #1;
    while (deviceReady !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
      i++;
      if (i > 400)
      begin
        n_mismatch++;
        $display("[ERR] %0t ready timeout", $time);
        summarize();
      end
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic setLoader(input logic p, input ssl_strap_t lim);
    m = 15'($random(seed)) & lim;
    v = 15'($random(seed));
    @(posedge sys_clk);
    present  <= p;
    ovrMask  <= m;
    ovrVal   <= v;
    delayCyc <= 4'($random(seed)) & 4'h7;
  endtask

  task automatic setPins(input int k);
    pv = $random(seed);
    if (k == 1)
      pv = 32'hFFFFFFFF;
    if (k == 2)
      pv = 32'h0;
    @(posedge sys_clk);
    indicatorSelectPin   <= pv[0];
    indicatorFunctionPin <= pv[2:1];
    autoCrossoverPin     <= pv[3];
    negotiationPin       <= pv[4];
  endtask

  task automatic checkAll(input ssl_strap_t e);
    regRead(8'h1C);
    check(rd, {1'b0, lat, 1'b0, e}, "strap status");
    regRead(8'h08);
    check(rd & 32'h3FF, {22'h0, e[9:0]}, "indicator cfg");
    check(32'(indicatorOutputSelect), 32'(e[7:0]), "select out");
    check(32'(indicatorFunctionField), 32'(e[9:8]), "function out");
    check(32'(autoCrossoverEn), 32'(e[10]), "auto crossover");
    if (!e[10])
      check(32'(crossedWiring), 32'(e[11]), "manual crossover");
    check(32'({negotiationEnable, speedSelectLow, duplexSelect, advert10Full,
               advert10Half, specialMode}), 32'(phyExp(phyS)), "port defaults");
  endtask

  initial
  begin
    seed = 80616;
    n_mismatch = 0;
    n_compared = 0;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    externalResetPinN = 1'b1;
    {regAddr, regWrData, regWrStb, regRdStb} = '0;
    {present, ovrMask, ovrVal, delayCyc} = '0;
    {indicatorSelectPin, indicatorFunctionPin, autoCrossoverPin, negotiationPin} = '0;
    for (int k = 0; k < 4; k++)
    begin
      setPins(k);
      lat = {`SSL_TIE_DPX, `SSL_TIE_SPD, pv[4], `SSL_TIE_MANX, pv[3], pv[2:1], {8{pv[0]}}};
      setLoader(1'b1, (k == 3) ? 15'h7FFF : 15'($random(seed)) & 15'h0FFF);
      // Reset pin and power-on alternate as the re-latch source
      if (k[0])
        externalResetPinN <= 1'b0;
      else
        rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      externalResetPinN <= 1'b1;
      waitReady();
      phyS = merge(lat, m, v);
      checkAll(phyS);
      setPins(0);
      setLoader(1'b0, 15'h7FFF);
      pv[7:0] = startCount;
      regWrite(8'h00, 32'h1);
      waitReady();
      check(32'(startCount), 32'(pv[7:0] + 8'h01), "loader rerun");
      checkAll(lat);
      setLoader(1'b1, 15'h7FFF);
      regWrite(8'h04, 32'h1);
      waitReady();
      checkAll(merge(lat, m, v));
      setLoader(1'b0, 15'h7FFF);
      regWrite(8'h04, 32'h1);
      waitReady();
      checkAll(lat);
    end
    for (int j = 0; j < 4; j++)
    begin
      regWrite(8'h18, 32'h8000 | (32'(j) << 13));
      repeat (2) @(posedge sys_clk);
      #1;
      check(32'(autoCrossoverEn), 32'(j[1]), "override auto");
      if (!j[1])
        check(32'(crossedWiring), 32'(j[0]), "override cross");
    end
    regWrite(8'h18, 32'h0);
    // Writes during loading are dropped, so this override must not stick
    setLoader(1'b0, 15'h0);
    @(posedge sys_clk);
    delayCyc <= 4'h8;
    regWrite(8'h00, 32'h1);
    regWrite(8'h18, 32'hE000);
    waitReady();
    regRead(8'h18);
    check(rd & 32'hE000, 32'h0, "write while loading");
    checkAll(lat);
    regRead(8'h20);
    check(rd, 32'h0, "unmapped read");
    regWrite(8'h1C, 32'hFFFFFFFF);
    regRead(8'h1C);
    check(rd, {1'b0, lat, 1'b0, lat}, "status is read only");
    // Frozen clock enable must drop an otherwise legal write
    @(posedge sys_clk);
    clkEn <= 1'b0;
    regWrite(8'h08, 32'(~lat[9:0]));
    clkEn <= 1'b1;
    regRead(8'h08);
    check(rd & 32'h3FF, {22'h0, lat[9:0]}, "write while frozen");
    summarize();
  end
endmodule
